//--- inc/rmc_pkg.sv
package rmc_pkg;

    // Register window: one byte per address, 0x17 up to 0x27.
    localparam int          RMC_NREG      = 17;
    localparam int          RMC_IDX_W     = 5;
    localparam logic [7:0]  RMC_BASE_ADDR = 8'h17;
    localparam logic [7:0]  RMC_LAST_ADDR = 8'h27;

    // Register addresses.
    localparam logic [7:0] RMC_A_LOWEST_SLOT   = 8'h17;
    localparam logic [7:0] RMC_A_PA_RAMP       = 8'h18;
    localparam logic [7:0] RMC_A_RATE_MANT     = 8'h1A;
    localparam logic [7:0] RMC_A_MODULATION    = 8'h1B;
    localparam logic [7:0] RMC_A_FREQ_DEV      = 8'h1C;
    localparam logic [7:0] RMC_A_CHAN_FILTER   = 8'h1D;
    localparam logic [7:0] RMC_A_FC_CONTROL    = 8'h1E;
    localparam logic [7:0] RMC_A_FC_FAST_LEN   = 8'h1F;
    localparam logic [7:0] RMC_A_FC_GAINS      = 8'h20;
    localparam logic [7:0] RMC_A_STRENGTH_FLT  = 8'h21;
    localparam logic [7:0] RMC_A_DETECT_TH     = 8'h22;
    localparam logic [7:0] RMC_A_CLOCK_REC     = 8'h23;
    localparam logic [7:0] RMC_A_GAIN_MEASURE  = 8'h24;
    localparam logic [7:0] RMC_A_GAIN_THRESH   = 8'h25;
    localparam logic [7:0] RMC_A_GAIN_ENABLE   = 8'h26;
    localparam logic [7:0] RMC_A_ANTENNA       = 8'h27;

    // Reset values, indexed by address minus base; 0x19 is a hole.
    localparam logic [7:0] RMC_RESET_VAL [RMC_NREG] = '{
        8'h00, 8'h07, 8'h00, 8'h83, 8'h1A, 8'h45, 8'h23, 8'h48, 8'h18,
        8'h25, 8'hE3, 8'h24, 8'h58, 8'h22, 8'h65, 8'h8A, 8'h05};

    // Writable bits; reserved read-only bits stay zero.
    localparam logic [7:0] RMC_WMASK [RMC_NREG] = '{
        8'h7F, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F};

    // Field positions.
    localparam int RMC_LEVEL_HI = 6, RMC_LEVEL_LO = 0;
    localparam int RMC_CAPS_HI = 7, RMC_CAPS_LO = 6;
    localparam int RMC_RAMP_ON_BIT = 5;
    localparam int RMC_STEP_HI = 4, RMC_STEP_LO = 3;
    localparam int RMC_FINAL_HI = 2, RMC_FINAL_LO = 0;
    localparam int RMC_CW_BIT = 7, RMC_BT_BIT = 6;
    localparam int RMC_MOD_HI = 5, RMC_MOD_LO = 4;
    localparam int RMC_RATE_E_HI = 3, RMC_RATE_E_LO = 0;
    localparam int RMC_DEV_E_HI = 7, RMC_DEV_E_LO = 4;
    localparam int RMC_LOOP_SEL_BIT = 3;
    localparam int RMC_DEV_M_HI = 2, RMC_DEV_M_LO = 0;
    localparam int RMC_HI_NIB_HI = 7, RMC_HI_NIB_LO = 4;
    localparam int RMC_LO_NIB_HI = 3, RMC_LO_NIB_LO = 0;
    localparam int RMC_FREEZE_BIT = 7, RMC_FC_ON_BIT = 6, RMC_FC_POINT_BIT = 5;
    localparam int RMC_LEAK_HI = 4, RMC_LEAK_LO = 0;
    localparam int RMC_DECAY_HI = 1, RMC_DECAY_LO = 0;
    localparam int RMC_PGAIN_HI = 7, RMC_PGAIN_LO = 5;
    localparam int RMC_PSTFLT_BIT = 4;
    localparam int RMC_AGC_ON_BIT = 7;
    localparam int RMC_BLANK_BIT = 4, RMC_ANT_ON_BIT = 3;
    localparam int RMC_ANT_T_HI = 2, RMC_ANT_T_LO = 0;

    // Modulation codes and timing loop selection.
    localparam logic [1:0] RMC_MOD_GFSK = 2'h1;
    localparam logic       RMC_LOOP_PLL = 1'h1;

    // Serial command byte: bit 0 high means read.
    localparam int RMC_CMD_RD_BIT = 0;
    localparam logic [2:0] RMC_LAST_BIT = 3'h7;
    localparam logic [1:0] RMC_DATA_PHASE = 2'h2;

    // Ramp sequencer states.
    typedef enum logic [2:0] {
        RMC_RAMP_IDLE = 3'b001,
        RMC_RAMP_STEP = 3'b010,
        RMC_RAMP_HOLD = 3'b100
    } rmc_ramp_state_type;

endpackage

//--- src/rmc_config_bank.sv
`timescale 1ns/1ps
module rmc_config_bank #(
    parameter int NUM_SLOTS  = 8,
    parameter int FAST_CNT_W = 8
) (
    input  wire logic                    sys_clk,
    input  wire logic                    nrst,
    input  wire logic                    clk_en,
    input  wire logic                    spi_csn,
    input  wire logic                    spi_sck,
    input  wire logic                    spi_mosi,
    output logic                         spi_miso,
    output logic                         spi_miso_oe,
    input  wire logic                    tx_on,
    input  wire logic                    eighth_bit_tick,
    input  wire logic                    rx_on,
    input  wire logic                    symbol_tick,
    input  wire logic                    sync_found,
    input  wire logic                    rx_data_valid,
    input  wire logic                    below_cs,
    output logic [2:0]                   pa_slot,
    output logic [6:0]                   lowest_slot_level,
    output logic [1:0]                   output_load_caps,
    output logic                         carrier_only_tx,
    output logic [1:0]                   modulation_select,
    output logic                         gauss_bt_select,
    output logic [7:0]                   rate_mantissa,
    output logic [3:0]                   rate_exponent,
    output logic [3:0]                   deviation_exponent,
    output logic [2:0]                   deviation_mantissa,
    output logic                         timing_loop_select,
    output logic [3:0]                   timing_integral_gain,
    output logic [2:0]                   timing_prop_gain,
    output logic                         post_filter_len,
    output logic [3:0]                   chan_filter_mantissa,
    output logic [3:0]                   chan_filter_exponent,
    output logic                         freq_corr_active,
    output logic                         freq_corr_loop_point,
    output logic [4:0]                   peak_detector_leak,
    output logic [3:0]                   freq_corr_gain,
    output logic [3:0]                   strength_filter_gain,
    output logic [1:0]                   onoff_peak_decay,
    output logic [7:0]                   detect_level,
    output logic                         auto_gain_on,
    output logic [3:0]                   gain_measure_time,
    output logic [3:0]                   gain_high_thresh,
    output logic [3:0]                   gain_low_thresh,
    output logic                         antenna_diversity_on,
    output logic [2:0]                   antenna_measure_time,
    output logic                         fifo_write
);
    import rmc_pkg::*;

    // Refuse sizes the slot index and the fast-period counter cannot serve.
    initial begin
        if (NUM_SLOTS != 8) $error("NUM_SLOTS must be 8.");
        if (FAST_CNT_W < 8) $error("FAST_CNT_W must be at least 8.");
    end

    logic [7:0]           regs_r [RMC_NREG];
    logic                 sck_q_r;
    logic [2:0]           bit_cnt_r;
    logic [1:0]           byte_cnt_r;
    logic [7:0]           shift_r;
    logic [7:0]           addr_r;
    logic                 cmd_rd_r;
    logic [7:0]           tx_byte_r;
    logic                 miso_r;
    logic                 miso_oe_r;
    rmc_ramp_state_type   ramp_st_r;
    logic [2:0]           slot_r;
    logic [2:0]           tick_cnt_r;
    logic                 frozen_r;
    logic                 corr_act_r;
    logic [FAST_CNT_W-1:0] fast_cnt_r;
    logic [3:0]           corr_gain_r;
    logic [3:0]           int_gain_r;
    logic                 fifo_wr_r;
    logic                 sck_rise;
    logic                 sck_fall;
    logic [7:0]           byte_in;
    logic                 byte_done;
    logic                 wr_strobe;
    logic [7:0]           rd_byte;

    // True when an address falls inside the register window.
    function automatic logic in_map(input logic [7:0] a);
        return (a >= RMC_BASE_ADDR) && (a <= RMC_LAST_ADDR);
    endfunction

    // Converts an address to an index into the register array.
    function automatic logic [RMC_IDX_W-1:0] to_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - RMC_BASE_ADDR;
        return d[RMC_IDX_W-1:0];
    endfunction

    // Readback value; addresses outside the window read as zero.
    function automatic logic [7:0] rd_val(input logic [7:0] a);
        return in_map(a) ? regs_r[to_idx(a)] : 8'h00;
    endfunction

    // Serial edges; pins are taken as synchronous to sys_clk.
    assign sck_rise  = spi_sck && !sck_q_r;
    assign sck_fall  = !spi_sck && sck_q_r;
    assign byte_in   = {shift_r[6:0], spi_mosi};
    assign byte_done = !spi_csn && sck_rise && (bit_cnt_r == RMC_LAST_BIT);
    assign wr_strobe = byte_done && (byte_cnt_r == RMC_DATA_PHASE) && !cmd_rd_r;

    // Readback byte for the current serial address, so its top bit can be picked.
    assign rd_byte   = rd_val(addr_r);

    // Serial receive: command byte, address byte, then data with auto-increment.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sck_q_r    <= 1'b0;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            shift_r    <= 8'h00;
            addr_r     <= 8'h00;
            cmd_rd_r   <= 1'b0;
        end else if (clk_en) begin
            sck_q_r <= spi_sck;
            if (spi_csn) begin
                bit_cnt_r  <= 3'h0;
                byte_cnt_r <= 2'h0;
            end else if (sck_rise) begin
                shift_r   <= byte_in;
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (byte_done) begin
                    unique case (byte_cnt_r)
                        2'h0: cmd_rd_r <= byte_in[RMC_CMD_RD_BIT];
                        2'h1: addr_r   <= byte_in;
                        default: addr_r <= addr_r + 8'h01;
                    endcase
                    if (byte_cnt_r != RMC_DATA_PHASE) begin
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                    end
                end
            end
        end
    end

    // Serial transmit: a read byte is latched on the first falling edge.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_byte_r <= 8'h00;
            miso_r    <= 1'b0;
            miso_oe_r <= 1'b0;
        end else if (clk_en) begin
            miso_oe_r <= !spi_csn;
            if (spi_csn) begin
                miso_r <= 1'b0;
            end else if (sck_fall && cmd_rd_r && (byte_cnt_r == RMC_DATA_PHASE)) begin
                if (bit_cnt_r == 3'h0) begin
                    tx_byte_r <= rd_byte;
                    miso_r    <= rd_byte[RMC_LAST_BIT];
                end else begin
                    miso_r <= tx_byte_r[~bit_cnt_r];
                end
            end
        end
    end

    // Register storage; only writable bits take host data.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < RMC_NREG; i++) begin
                regs_r[i] <= RMC_RESET_VAL[i];
            end
        end else if (clk_en && wr_strobe && in_map(addr_r)) begin
            regs_r[to_idx(addr_r)] <= (byte_in & RMC_WMASK[to_idx(addr_r)])
                | (regs_r[to_idx(addr_r)] & ~RMC_WMASK[to_idx(addr_r)]);
        end
    end

    // Power ramp: climbs from slot 0 to the final index, one step per width.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ramp_st_r  <= RMC_RAMP_IDLE;
            slot_r     <= 3'h0;
            tick_cnt_r <= 3'h0;
        end else if (clk_en) begin
            unique case (ramp_st_r)
                RMC_RAMP_IDLE: begin
                    tick_cnt_r <= 3'h0;
                    if (!tx_on) begin
                        slot_r <= 3'h0;
                    end else if (regs_r[to_idx(RMC_A_PA_RAMP)][RMC_RAMP_ON_BIT]) begin
                        slot_r    <= 3'h0;
                        ramp_st_r <= RMC_RAMP_STEP;
                    end else begin
                        slot_r    <= regs_r[to_idx(RMC_A_PA_RAMP)][RMC_FINAL_HI:RMC_FINAL_LO];
                        ramp_st_r <= RMC_RAMP_HOLD;
                    end
                end
                RMC_RAMP_STEP: begin
                    if (!tx_on) begin
                        ramp_st_r <= RMC_RAMP_IDLE;
                        slot_r    <= 3'h0;
                    end else if (slot_r >= regs_r[to_idx(RMC_A_PA_RAMP)][RMC_FINAL_HI:RMC_FINAL_LO]) begin
                        ramp_st_r <= RMC_RAMP_HOLD;
                    end else if (eighth_bit_tick) begin
                        if (tick_cnt_r[1:0] == regs_r[to_idx(RMC_A_PA_RAMP)][RMC_STEP_HI:RMC_STEP_LO]) begin
                            tick_cnt_r <= 3'h0;
                            slot_r     <= slot_r + 3'h1;
                        end else begin
                            tick_cnt_r <= tick_cnt_r + 3'h1;
                        end
                    end
                end
                RMC_RAMP_HOLD: begin
                    if (!tx_on) begin
                        ramp_st_r <= RMC_RAMP_IDLE;
                        slot_r    <= 3'h0;
                    end
                end
            endcase
        end
    end

    // Frequency correction: freeze latch, fast period and gain selection.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frozen_r    <= 1'b0;
            corr_act_r  <= 1'b0;
            fast_cnt_r  <= '0;
            corr_gain_r <= 4'h0;
        end else if (clk_en) begin
            if (sync_found && regs_r[to_idx(RMC_A_FC_CONTROL)][RMC_FREEZE_BIT]) begin
                frozen_r <= 1'b1;
            end else if (!rx_on) begin
                frozen_r <= 1'b0;
            end
            corr_act_r <= regs_r[to_idx(RMC_A_FC_CONTROL)][RMC_FC_ON_BIT] && rx_on
                && !frozen_r;
            if (!rx_on) begin
                fast_cnt_r <= '0;
            end else if (symbol_tick && (fast_cnt_r < FAST_CNT_W'(regs_r[to_idx(RMC_A_FC_FAST_LEN)]))) begin
                fast_cnt_r <= fast_cnt_r + 1'b1;
            end
            corr_gain_r <= (fast_cnt_r < FAST_CNT_W'(regs_r[to_idx(RMC_A_FC_FAST_LEN)]))
                ? regs_r[to_idx(RMC_A_FC_GAINS)][RMC_HI_NIB_HI:RMC_HI_NIB_LO]
                : regs_r[to_idx(RMC_A_FC_GAINS)][RMC_LO_NIB_HI:RMC_LO_NIB_LO];
        end
    end

    // Integral gain is only handed on in PLL mode; FIFO writes honour blanking.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            int_gain_r <= 4'h0;
            fifo_wr_r  <= 1'b0;
        end else if (clk_en) begin
            int_gain_r <= (regs_r[to_idx(RMC_A_FREQ_DEV)][RMC_LOOP_SEL_BIT] == RMC_LOOP_PLL)
                ? regs_r[to_idx(RMC_A_CLOCK_REC)][RMC_LO_NIB_HI:RMC_LO_NIB_LO] : 4'h0;
            fifo_wr_r <= rx_data_valid
                && !(regs_r[to_idx(RMC_A_ANTENNA)][RMC_BLANK_BIT] && below_cs);
        end
    end

    // Outputs come straight from register flops.
    assign spi_miso             = miso_r;
    assign spi_miso_oe          = miso_oe_r;
    assign pa_slot              = slot_r;
    assign freq_corr_active     = corr_act_r;
    assign freq_corr_gain       = corr_gain_r;
    assign timing_integral_gain = int_gain_r;
    assign fifo_write           = fifo_wr_r;
    assign lowest_slot_level    = regs_r[to_idx(RMC_A_LOWEST_SLOT)][RMC_LEVEL_HI:RMC_LEVEL_LO];
    assign output_load_caps     = regs_r[to_idx(RMC_A_PA_RAMP)][RMC_CAPS_HI:RMC_CAPS_LO];
    assign carrier_only_tx      = regs_r[to_idx(RMC_A_MODULATION)][RMC_CW_BIT];
    assign gauss_bt_select      = regs_r[to_idx(RMC_A_MODULATION)][RMC_BT_BIT];
    assign modulation_select    = regs_r[to_idx(RMC_A_MODULATION)][RMC_MOD_HI:RMC_MOD_LO];
    assign rate_mantissa        = regs_r[to_idx(RMC_A_RATE_MANT)];
    assign rate_exponent        = regs_r[to_idx(RMC_A_MODULATION)][RMC_RATE_E_HI:RMC_RATE_E_LO];
    assign deviation_exponent   = regs_r[to_idx(RMC_A_FREQ_DEV)][RMC_DEV_E_HI:RMC_DEV_E_LO];
    assign deviation_mantissa   = regs_r[to_idx(RMC_A_FREQ_DEV)][RMC_DEV_M_HI:RMC_DEV_M_LO];
    assign timing_loop_select   = regs_r[to_idx(RMC_A_FREQ_DEV)][RMC_LOOP_SEL_BIT];
    assign chan_filter_mantissa = regs_r[to_idx(RMC_A_CHAN_FILTER)][RMC_HI_NIB_HI:RMC_HI_NIB_LO];
    assign chan_filter_exponent = regs_r[to_idx(RMC_A_CHAN_FILTER)][RMC_LO_NIB_HI:RMC_LO_NIB_LO];
    assign freq_corr_loop_point = regs_r[to_idx(RMC_A_FC_CONTROL)][RMC_FC_POINT_BIT];
    assign peak_detector_leak   = regs_r[to_idx(RMC_A_FC_CONTROL)][RMC_LEAK_HI:RMC_LEAK_LO];
    assign strength_filter_gain = regs_r[to_idx(RMC_A_STRENGTH_FLT)][RMC_HI_NIB_HI:RMC_HI_NIB_LO];
    assign onoff_peak_decay     = regs_r[to_idx(RMC_A_STRENGTH_FLT)][RMC_DECAY_HI:RMC_DECAY_LO];
    assign detect_level         = regs_r[to_idx(RMC_A_DETECT_TH)];
    assign timing_prop_gain     = regs_r[to_idx(RMC_A_CLOCK_REC)][RMC_PGAIN_HI:RMC_PGAIN_LO];
    assign post_filter_len      = regs_r[to_idx(RMC_A_CLOCK_REC)][RMC_PSTFLT_BIT];
    assign gain_measure_time    = regs_r[to_idx(RMC_A_GAIN_MEASURE)][RMC_LO_NIB_HI:RMC_LO_NIB_LO];
    assign gain_high_thresh     = regs_r[to_idx(RMC_A_GAIN_THRESH)][RMC_HI_NIB_HI:RMC_HI_NIB_LO];
    assign gain_low_thresh      = regs_r[to_idx(RMC_A_GAIN_THRESH)][RMC_LO_NIB_HI:RMC_LO_NIB_LO];
    assign auto_gain_on         = regs_r[to_idx(RMC_A_GAIN_ENABLE)][RMC_AGC_ON_BIT];
    assign antenna_diversity_on = regs_r[to_idx(RMC_A_ANTENNA)][RMC_ANT_ON_BIT];
    assign antenna_measure_time = regs_r[to_idx(RMC_A_ANTENNA)][RMC_ANT_T_HI:RMC_ANT_T_LO];

    // Checks on the block's own behaviour.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_write_lands: assert property (
        clk_en && wr_strobe && (addr_r == RMC_A_MODULATION)
        |=> modulation_select == $past(byte_in[RMC_MOD_HI:RMC_MOD_LO]))
        else $error("Modulation write did not land.");
    chk_level_reserved: assert property (
        regs_r[to_idx(RMC_A_LOWEST_SLOT)][RMC_LAST_BIT] == 1'b0)
        else $error("Reserved level bit became set.");
    chk_fixed_slot: assert property (
        clk_en && (ramp_st_r == RMC_RAMP_IDLE) && tx_on
        && !regs_r[to_idx(RMC_A_PA_RAMP)][RMC_RAMP_ON_BIT]
        |=> pa_slot == $past(regs_r[to_idx(RMC_A_PA_RAMP)][RMC_FINAL_HI:RMC_FINAL_LO]))
        else $error("Fixed power slot not applied.");
    chk_ramp_single: assert property (
        ramp_st_r == RMC_RAMP_STEP && $past(ramp_st_r) == RMC_RAMP_STEP
        |-> (pa_slot - $past(pa_slot)) <= 3'h1)
        else $error("Ramp jumped more than one slot.");
    chk_step_width: assert property (
        clk_en && ramp_st_r == RMC_RAMP_STEP && tx_on && eighth_bit_tick
        && tick_cnt_r[1:0] != regs_r[to_idx(RMC_A_PA_RAMP)][RMC_STEP_HI:RMC_STEP_LO]
        |=> $stable(pa_slot))
        else $error("Ramp stepped before its width elapsed.");
    chk_fifo_blank: assert property (
        clk_en && rx_data_valid && below_cs && regs_r[to_idx(RMC_A_ANTENNA)][RMC_BLANK_BIT]
        |=> !fifo_write)
        else $error("Blanked data reached the FIFO.");
    chk_freeze_sync: assert property (
        clk_en && sync_found && rx_on && regs_r[to_idx(RMC_A_FC_CONTROL)][RMC_FREEZE_BIT]
        ##1 clk_en && rx_on |=> !freq_corr_active)
        else $error("Correction kept running after sync freeze.");
    chk_slow_gain: assert property (
        clk_en && rx_on && $past(clk_en)
        && fast_cnt_r >= FAST_CNT_W'(regs_r[to_idx(RMC_A_FC_FAST_LEN)])
        |=> freq_corr_gain == $past(regs_r[to_idx(RMC_A_FC_GAINS)][RMC_LO_NIB_HI:RMC_LO_NIB_LO]))
        else $error("Slow gain not used after fast period.");
    chk_pll_gain: assert property (
        clk_en && timing_loop_select != RMC_LOOP_PLL |=> timing_integral_gain == 4'h0)
        else $error("Integral gain leaked in DLL mode.");
    chk_tx_off_slot: assert property (
        clk_en && !tx_on |=> pa_slot == 3'h0)
        else $error("Power slot not cleared with transmitter off.");
    chk_corr_off: assert property (
        clk_en && !regs_r[to_idx(RMC_A_FC_CONTROL)][RMC_FC_ON_BIT] |=> !freq_corr_active)
        else $error("Correction ran while disabled.");
    chk_fifo_pass: assert property (
        clk_en && rx_data_valid && !below_cs |=> fifo_write)
        else $error("Strong-signal data did not reach the FIFO.");
    chk_fast_gain: assert property (
        clk_en && fast_cnt_r < FAST_CNT_W'(regs_r[to_idx(RMC_A_FC_FAST_LEN)])
        |=> freq_corr_gain == $past(regs_r[to_idx(RMC_A_FC_GAINS)][RMC_HI_NIB_HI:RMC_HI_NIB_LO]))
        else $error("Fast gain not used during fast period.");
    chk_miso_quiet: assert property (
        spi_csn ##1 spi_csn |-> !spi_miso_oe)
        else $error("MISO driven while deselected.");

    cov_ramp_done: cover property (ramp_st_r == RMC_RAMP_STEP ##1 ramp_st_r == RMC_RAMP_HOLD);
    cov_reg_read: cover property (sck_fall && cmd_rd_r && byte_cnt_r == RMC_DATA_PHASE);
    cov_freeze: cover property (frozen_r && rx_on);
    cov_blanked: cover property (rx_data_valid && below_cs && !fifo_write);

endmodule

//--- tb/rmc_host.sv
`timescale 1ns/1ps
// Host side of the serial port: mode 0, MSB first, four system cycles per bit.
module rmc_host (
    input  wire logic sys_clk,
    input  wire logic spi_miso,
    output logic      spi_csn,
    output logic      spi_sck,
    output logic      spi_mosi
);
    // The port idles deselected with the serial clock low.
    initial begin
        spi_csn = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end

    // One frame of command, address and one data byte; rd keeps the last byte.
    task automatic frame(input logic [7:0] cmd, input logic [7:0] adr,
                         input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] sh;
        sh = {cmd, adr, wd};
        rd = 8'h00;
        spi_csn = 1'b0;
        @(posedge sys_clk) #1;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi = sh[i];
            spi_sck = 1'b1;
            repeat (2) @(posedge sys_clk);
            #1 rd[i % 8] = spi_miso;
            spi_sck = 1'b0;
            repeat (2) @(posedge sys_clk);
            #1;
        end
        spi_csn = 1'b1;
        spi_mosi = ~spi_mosi; // A released line must not keep its last value.
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
endmodule

//--- tb/radio_modem_config_bank_test.sv
`timescale 1ns/1ps
`define RMC_CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
// Drives the register bank through its serial port and its radio-side inputs.
module radio_modem_config_bank_test;
    import rmc_pkg::*;
    logic sys_clk, nrst, clk_en, spi_csn, spi_sck, spi_mosi, spi_miso, spi_miso_oe, tx_on;
    logic eighth_bit_tick, rx_on, symbol_tick, sync_found, rx_data_valid, below_cs;
    logic carrier_only_tx, gauss_bt_select, timing_loop_select, post_filter_len, fifo_write;
    logic freq_corr_active, freq_corr_loop_point, auto_gain_on, antenna_diversity_on;
    logic [1:0] output_load_caps, modulation_select, onoff_peak_decay;
    logic [2:0] pa_slot, deviation_mantissa, timing_prop_gain, antenna_measure_time;
    logic [3:0] rate_exponent, deviation_exponent, timing_integral_gain, freq_corr_gain;
    logic [3:0] chan_filter_mantissa, chan_filter_exponent, strength_filter_gain;
    logic [3:0] gain_measure_time, gain_high_thresh, gain_low_thresh;
    logic [4:0] peak_detector_leak;
    logic [6:0] lowest_slot_level;
    logic [7:0] rate_mantissa, detect_level, rd;
    int fail_count = 0, total_checks = 0, cycles = 0;

    rmc_config_bank DUT (.*);
    rmc_host host (.*);

    // The clock runs at 10 MHz.
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.frame(8'h00, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.frame(8'h01, a, 8'h00, rd);
        `RMC_CHK(rd, e)
    endtask

    task automatic t_reset;
        `RMC_CHK({output_load_caps, lowest_slot_level}, 9'h000)
        `RMC_CHK({carrier_only_tx, gauss_bt_select, timing_loop_select}, 3'h0)
        `RMC_CHK({modulation_select, rate_mantissa, rate_exponent}, 14'h183A)
        `RMC_CHK({deviation_exponent, deviation_mantissa}, 7'h25)
        `RMC_CHK({chan_filter_mantissa, chan_filter_exponent}, 8'h23)
        `RMC_CHK({strength_filter_gain, onoff_peak_decay}, 6'h3B)
        `RMC_CHK({detect_level, timing_prop_gain, post_filter_len}, 12'h245)
        `RMC_CHK({auto_gain_on, gain_high_thresh, gain_low_thresh}, 9'h165)
        `RMC_CHK(gain_measure_time, 4'h2)
        `RMC_CHK({antenna_diversity_on, antenna_measure_time}, 4'h5)
        `RMC_CHK({freq_corr_loop_point, peak_detector_leak, timing_integral_gain}, 10'h080)
        rdc(RMC_A_GAIN_ENABLE, 8'h8A);
        rdc(8'h19, 8'h00);
        $display("reset values done");
    endtask

    task automatic t_power;
        wr(RMC_A_LOWEST_SLOT, 8'hFF);
        rdc(RMC_A_LOWEST_SLOT, 8'h7F);
        wr(RMC_A_PA_RAMP, 8'hEA);
        `RMC_CHK(output_load_caps, 2'h3)
        tx_on = 1'b1;
        cyc(2);
        `RMC_CHK(pa_slot, 3'h0)
        for (int k = 1; k <= 6; k++) begin
            pulse(eighth_bit_tick);
            `RMC_CHK(pa_slot, (k > 4) ? 3'h2 : 3'(k / 2))
        end
        tx_on = 1'b0;
        wr(RMC_A_PA_RAMP, 8'h04);
        tx_on = 1'b1;
        cyc(2);
        `RMC_CHK(pa_slot, 3'h4)
        tx_on = 1'b0;
        $display("power ramp done");
    endtask

    task automatic t_mod;
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v = {k[0], k[1], 2'(k), 4'hA};
            wr(RMC_A_MODULATION, v);
            `RMC_CHK({carrier_only_tx, gauss_bt_select, modulation_select}, v[7:4])
        end
        wr(RMC_A_FREQ_DEV, 8'h4D);
        `RMC_CHK({timing_loop_select, timing_integral_gain}, 5'h18)
        $display("modulation done");
    endtask

    task automatic t_rx;
        rx_on = 1'b1;
        cyc(2);
        `RMC_CHK({freq_corr_active, freq_corr_gain}, 5'h12)
        wr(RMC_A_FC_FAST_LEN, 8'h01);
        pulse(symbol_tick);
        pulse(symbol_tick);
        `RMC_CHK(freq_corr_gain, 4'h5)
        wr(RMC_A_FC_CONTROL, 8'hC8);
        pulse(sync_found);
        cyc(1);
        `RMC_CHK(freq_corr_active, 1'b0)
        rx_on = 1'b0;
        $display("frequency correction done");
    endtask

    task automatic t_blank;
        wr(RMC_A_ANTENNA, 8'h1D);
        `RMC_CHK({antenna_diversity_on, antenna_measure_time}, 4'hD)
        below_cs = 1'b1;
        for (int k = 0; k < 2; k++) begin
            rx_data_valid = 1'b1;
            cyc(1);
            `RMC_CHK(fifo_write, 1'(k))
            rx_data_valid = 1'b0;
            below_cs = 1'b0;
            cyc(1);
        end
        $display("fifo blanking done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reset for eight cycles, then run each scenario in turn.
    initial begin
        {nrst, tx_on, eighth_bit_tick, rx_on, symbol_tick, sync_found} = '0;
        {rx_data_valid, below_cs} = '0;
        clk_en = 1'b1;
        cyc(8);
        nrst = 1'b1;
        cyc(1);
        t_reset();
        t_power();
        t_mod();
        t_rx();
        t_blank();
        wrap_up();
    end
endmodule
